// ---- glcd_dev.sv ----
`timescale 1ns/1ps
`default_nettype none
module glcd_dev
    import glcd_pkg::*;
#(
    parameter int BUSY_CYCLES = BUSY_CYC,
    parameter int INIT_CYCLES = INIT_CYC
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    glcd_bus_if.dev bus,
    input wire logic [5:0] scan_row_i,
    input wire logic [5:0] scan_col_i,
    output logic scan_pix_o,
    output logic disp_on_o,
    output logic [5:0] start_line_o,
    output logic busy_o
);
    // Busy window must sit between one and three phase clocks
    localparam int BUSY_MIN = (PHI_CYC_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_MAX = (3 * PHI_CYC_NS) / CLK_NS;

    if (BUSY_CYCLES < BUSY_MIN || BUSY_CYCLES > BUSY_MAX || BUSY_CYCLES > 65535) begin : g_busy_chk
        $error("BUSY_CYCLES out of range");
    end
    if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin : g_init_chk
        $error("INIT_CYCLES out of range");
    end

    localparam logic [15:0] BUSY_LOAD = 16'(BUSY_CYCLES);
    localparam logic [15:0] INIT_LOAD = 16'(INIT_CYCLES);

    logic [13:0] pins_s;
    logic res_s;
    logic cs_l_s;
    logic cs_r_s;
    logic di_s;
    logic rw_s;
    logic en_s;
    logic [7:0] db_s;
    logic en_d_r;
    logic sel;
    logic fall;
    glcd_op_t op;
    logic accept;
    logic busy;
    logic init;
    logic disp_on_r;
    logic [5:0] start_r;
    logic [2:0] page_r;
    logic [5:0] col_r;
    logic [7:0] out_r;
    logic [15:0] busy_cnt_r;
    logic [15:0] init_cnt_r;
    logic [7:0] ram_r [0:511];
    logic [5:0] line;
    logic [7:0] scan_byte;
    logic [7:0] dout_r;
    logic oe_r;
    logic pix_r;
    logic busy_r;

    // Every pin is asynchronous to mclk_i
    glcd_sync #(
        .W(14)
    ) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i({bus.res_n, bus.chip_select_left, bus.chip_select_right,
              bus.di, bus.rw, bus.en, bus.db}),
        .q_o(pins_s)
    );

    assign {res_s, cs_l_s, cs_r_s, di_s, rw_s, en_s, db_s} = pins_s;

    // Enable history for the falling-edge strobe
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            en_d_r <= 1'b0;
        end else begin
            en_d_r <= en_s;
        end
    end

    // Strobe and acceptance
    assign sel = cs_l_s & cs_r_s;
    assign fall = en_d_r & ~en_s & sel;
    assign op = glcd_decode(rw_s, di_s, db_s);
    assign busy = (busy_cnt_r != 16'h0000);
    assign init = (init_cnt_r != 16'h0000) | ~res_s;
    // Status reads and undefined codes never start anything
    assign accept = fall & ~busy & ~init
                    & (op != GLCD_OP_STATUS) & (op != GLCD_OP_NONE);

    // Initialization window: held while pin reset low, then a short tail
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            init_cnt_r <= INIT_LOAD;
        end else if (!res_s) begin
            init_cnt_r <= INIT_LOAD;
        end else if (init_cnt_r != 16'h0000) begin
            init_cnt_r <= init_cnt_r - 16'h0001;
        end
    end

    // Busy timer, restarted by every accepted instruction
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_cnt_r <= 16'h0000;
        end else if (!res_s) begin
            busy_cnt_r <= 16'h0000;
        end else if (accept) begin
            busy_cnt_r <= BUSY_LOAD;
        end else if (busy) begin
            busy_cnt_r <= busy_cnt_r - 16'h0001;
        end
    end

    // Display on/off; forced off by either reset
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            disp_on_r <= 1'b0;
        end else if (!res_s) begin
            disp_on_r <= 1'b0;
        end else if (accept && op == GLCD_OP_ONOFF) begin
            disp_on_r <= db_s[0];
        end
    end

    // Start line register
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            start_r <= START_RST;
        end else if (!res_s) begin
            start_r <= START_RST;
        end else if (accept && op == GLCD_OP_START) begin
            start_r <= db_s[5:0];
        end
    end

    // Page register holds until the next set-page
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            page_r <= PAGE_RST;
        end else if (accept && op == GLCD_OP_PAGE) begin
            page_r <= db_s[2:0];
        end
    end

    // Column counter; six bits so the increment wraps by itself
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            col_r <= COL_RST;
        end else if (accept && op == GLCD_OP_COL) begin
            col_r <= db_s[5:0];
        end else if (accept && (op == GLCD_OP_WR || op == GLCD_OP_RD)) begin
            col_r <= col_r + 6'h01;
        end
    end

    // Display RAM, page-major; never cleared by display off
    always_ff @(posedge mclk_i) begin
        if (accept && op == GLCD_OP_WR) begin
            ram_r[{page_r, col_r}] <= db_s;
        end
    end

    // Output register refilled only by data reads, hence the dummy read
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            out_r <= 8'h00;
        end else if (accept && op == GLCD_OP_RD) begin
            out_r <= ram_r[{page_r, col_r}];
        end
    end

    // Bus drive while enable is high on a selected read
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            oe_r <= 1'b0;
            dout_r <= 8'h00;
        end else begin
            oe_r <= sel & rw_s & en_s;
            dout_r <= 8'h00;
            if (di_s) begin
                dout_r <= out_r;
            end else begin
                dout_r[ST_BUSY_BIT] <= busy;
                dout_r[ST_OFF_BIT] <= ~disp_on_r;
                dout_r[ST_RST_BIT] <= init;
            end
        end
    end

    // Panel scan: row zero shows the start line
    assign line = start_r + scan_row_i;
    assign scan_byte = ram_r[{line[5:3], scan_col_i}];

    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pix_r <= 1'b0;
        end else begin
            pix_r <= disp_on_r & scan_byte[line[2:0]];
        end
    end

    // Registered copy of busy for the user side
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            busy_r <= 1'b0;
        end else begin
            busy_r <= busy;
        end
    end

    assign bus.dev_db = dout_r;
    assign bus.dev_db_oe = oe_r;
    assign scan_pix_o = pix_r;
    assign disp_on_o = disp_on_r;
    assign start_line_o = start_r;
    assign busy_o = busy_r;
endmodule
`default_nettype wire

// ---- glcd_pkg.sv ----
package glcd_pkg;

    // Clock and bus timing, in ns unless named _CYC; BUSY_PHI counts phase clocks
    localparam int CLK_NS = 20;
    localparam int T_AS_NS = 140;
    localparam int T_WHE_NS = 450;
    localparam int T_WLE_NS = 450;
    localparam int T_RST_NS = 1000;
    localparam int INIT_NS = 1000;
    localparam int PHI_CYC_NS = 2500;
    localparam int BUSY_PHI = 2;
    localparam int BUSY_NS = BUSY_PHI * PHI_CYC_NS;
    localparam int AS_CYC = (T_AS_NS + CLK_NS - 1) / CLK_NS;
    localparam int WHE_CYC = (T_WHE_NS + CLK_NS - 1) / CLK_NS;
    localparam int WLE_CYC = (T_WLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_CYC = (T_RST_NS + CLK_NS - 1) / CLK_NS;
    localparam int INIT_CYC = (INIT_NS + CLK_NS - 1) / CLK_NS;
    localparam int BUSY_CYC = (BUSY_NS + CLK_NS - 1) / CLK_NS;

    // Instruction patterns on the data byte
    localparam logic [6:0] ONOFF_PAT = 7'h1f;
    localparam logic [1:0] START_PAT = 2'h3;
    localparam logic [4:0] PAGE_PAT = 5'h17;
    localparam logic [1:0] COL_PAT = 2'h1;

    // Status byte layout
    localparam int ST_BUSY_BIT = 7;
    localparam int ST_OFF_BIT = 5;
    localparam int ST_RST_BIT = 4;

    // Reset values and idle bus level
    localparam logic [5:0] START_RST = 6'h00;
    localparam logic [2:0] PAGE_RST = 3'h0;
    localparam logic [5:0] COL_RST = 6'h00;
    localparam logic [7:0] BUS_IDLE = 8'hff;

    typedef enum logic [2:0] {
        GLCD_OP_NONE, GLCD_OP_ONOFF, GLCD_OP_START, GLCD_OP_PAGE,
        GLCD_OP_COL, GLCD_OP_STATUS, GLCD_OP_WR, GLCD_OP_RD
    } glcd_op_t;

    // Decode one bus cycle from rw, di and the byte
    function automatic glcd_op_t glcd_decode(input logic rw, input logic di, input logic [7:0] d);
        glcd_op_t op;
        op = GLCD_OP_NONE;
        if (di) begin
            op = rw ? GLCD_OP_RD : GLCD_OP_WR;
        end else if (rw) begin
            op = GLCD_OP_STATUS;
        end else if (d[7:1] == ONOFF_PAT) begin
            op = GLCD_OP_ONOFF;
        end else if (d[7:6] == START_PAT) begin
            op = GLCD_OP_START;
        end else if (d[7:3] == PAGE_PAT) begin
            op = GLCD_OP_PAGE;
        end else if (d[7:6] == COL_PAT) begin
            op = GLCD_OP_COL;
        end
        return op;
    endfunction

endpackage

// ---- glcd_bus_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface glcd_bus_if;
    logic chip_select_left;
    logic chip_select_right;
    logic di;
    logic rw;
    logic en;
    logic res_n;
    logic [7:0] host_db;
    logic host_db_oe;
    logic [7:0] dev_db;
    logic dev_db_oe;
    logic [7:0] db;

    // Resolved bus level; an undriven bus reads as pulled high
    assign db = dev_db_oe ? dev_db : (host_db_oe ? host_db : glcd_pkg::BUS_IDLE);

    modport dev (
        input chip_select_left, chip_select_right, di, rw, en, res_n, db,
        output dev_db, dev_db_oe
    );
    modport host (
        output chip_select_left, chip_select_right, di, rw, en, res_n, host_db, host_db_oe,
        input db
    );
endinterface
`default_nettype wire

// ---- glcd_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module glcd_sync #(
    parameter int W = 1
) (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta_r;

    // Two-stage synchroniser; only the second stage is read outside
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta_r <= '0;
            q_o <= '0;
        end else begin
            meta_r <= d_i;
            q_o <= meta_r;
        end
    end
endmodule
`default_nettype wire

// ---- glcd_host.sv ----
`timescale 1ns/1ps
`default_nettype none
module glcd_host
    import glcd_pkg::*;
(
    input wire logic mclk_i,
    input wire logic nrst_i,
    glcd_bus_if.host bus,
    input wire logic panel_reset_i,
    input wire logic cmd_valid_i,
    input wire logic cmd_di_i,
    input wire logic cmd_rw_i,
    input wire logic [7:0] cmd_data_i,
    output logic cmd_ready_o,
    output logic rsp_valid_o,
    output logic [7:0] rsp_data_o
);
    typedef enum logic [2:0] {H_IDLE, H_SETUP, H_HIGH, H_LOW} glcd_hst_t;
    typedef enum logic [1:0] {K_POLL, K_DUMMY, K_REAL} glcd_kind_t;

    glcd_hst_t st_r;
    glcd_kind_t kind_r;
    logic [7:0] cnt_r;
    logic [7:0] db_s;
    logic [7:0] smp_r;
    logic c_di_r;
    logic c_rw_r;
    logic [7:0] c_data_r;
    logic need_dummy_r;
    logic cs_r;
    logic en_r;
    logic di_r;
    logic rw_r;
    logic [7:0] hdb_r;
    logic hdb_oe_r;
    logic [7:0] rst_cnt_r;
    logic res_n_r;
    logic ready_r;
    logic rsp_v_r;
    logic [7:0] rsp_r;

    glcd_sync #(
        .W(8)
    ) u_sync (
        .mclk_i(mclk_i),
        .nrst_i(nrst_i),
        .d_i(bus.db),
        .q_o(db_s)
    );

    // Reset pin stretched to the least reset time
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_cnt_r <= 8'(RST_CYC);
            res_n_r <= 1'b0;
        end else if (panel_reset_i) begin
            rst_cnt_r <= 8'(RST_CYC);
            res_n_r <= 1'b0;
        end else if (rst_cnt_r != 8'h00) begin
            rst_cnt_r <= rst_cnt_r - 8'h01;
        end else begin
            res_n_r <= 1'b1;
        end
    end

    // Bus cycle sequencer: every command except a status read is preceded by a status poll,
    // and a data read after any write gets one discarded dummy read first
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_r <= H_IDLE;
            kind_r <= K_POLL;
            cnt_r <= 8'h00;
            smp_r <= 8'h00;
            c_di_r <= 1'b0;
            c_rw_r <= 1'b0;
            c_data_r <= 8'h00;
            need_dummy_r <= 1'b1;
            cs_r <= 1'b0;
            en_r <= 1'b0;
            di_r <= 1'b0;
            rw_r <= 1'b1;
            hdb_r <= 8'h00;
            hdb_oe_r <= 1'b0;
            ready_r <= 1'b0;
            rsp_v_r <= 1'b0;
            rsp_r <= 8'h00;
        end else begin
            ready_r <= 1'b0;
            rsp_v_r <= 1'b0;
            unique case (st_r)
                H_IDLE: begin
                    cs_r <= 1'b0;
                    hdb_oe_r <= 1'b0;
                    if (cmd_valid_i && res_n_r) begin
                        ready_r <= 1'b1;
                        c_di_r <= cmd_di_i;
                        c_rw_r <= cmd_rw_i;
                        c_data_r <= cmd_data_i;
                        cs_r <= 1'b1;
                        cnt_r <= 8'(AS_CYC);
                        st_r <= H_SETUP;
                        // Status read needs no poll of its own
                        if (glcd_decode(cmd_rw_i, cmd_di_i, cmd_data_i) == GLCD_OP_STATUS) begin
                            kind_r <= K_REAL;
                            di_r <= 1'b0;
                            rw_r <= 1'b1;
                        end else begin
                            kind_r <= K_POLL;
                            di_r <= 1'b0;
                            rw_r <= 1'b1;
                        end
                    end
                end
                H_SETUP: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        en_r <= 1'b1;
                        cnt_r <= 8'(WHE_CYC);
                        st_r <= H_HIGH;
                    end
                end
                H_HIGH: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        smp_r <= db_s;
                        en_r <= 1'b0;
                        cnt_r <= 8'(WLE_CYC);
                        st_r <= H_LOW;
                    end
                end
                H_LOW: begin
                    cnt_r <= cnt_r - 8'h01;
                    if (cnt_r == 8'h01) begin
                        hdb_oe_r <= 1'b0;
                        cnt_r <= 8'(AS_CYC);
                        st_r <= H_SETUP;
                        unique case (kind_r)
                            K_POLL: begin
                                if (smp_r[ST_BUSY_BIT] || smp_r[ST_RST_BIT]) begin
                                    kind_r <= K_POLL;
                                end else if (c_di_r && c_rw_r && need_dummy_r) begin
                                    kind_r <= K_DUMMY;
                                    di_r <= 1'b1;
                                    rw_r <= 1'b1;
                                end else begin
                                    kind_r <= K_REAL;
                                    di_r <= c_di_r;
                                    rw_r <= c_rw_r;
                                    hdb_r <= c_data_r;
                                    hdb_oe_r <= ~c_rw_r;
                                end
                            end
                            K_DUMMY: begin
                                need_dummy_r <= 1'b0;
                                kind_r <= K_POLL;
                                di_r <= 1'b0;
                                rw_r <= 1'b1;
                            end
                            K_REAL: begin
                                if (c_rw_r) begin
                                    rsp_v_r <= 1'b1;
                                    rsp_r <= smp_r;
                                end else begin
                                    need_dummy_r <= 1'b1;
                                end
                                cs_r <= 1'b0;
                                rw_r <= 1'b1;
                                st_r <= H_IDLE;
                            end
                            default: begin
                                st_r <= H_IDLE;
                            end
                        endcase
                    end
                end
                default: begin
                    st_r <= H_IDLE;
                end
            endcase
        end
    end

    assign bus.chip_select_left = cs_r;
    assign bus.chip_select_right = cs_r;
    assign bus.di = di_r;
    assign bus.rw = rw_r;
    assign bus.en = en_r;
    assign bus.res_n = res_n_r;
    assign bus.host_db = hdb_r;
    assign bus.host_db_oe = hdb_oe_r;
    assign cmd_ready_o = ready_r;
    assign rsp_valid_o = rsp_v_r;
    assign rsp_data_o = rsp_r;
endmodule
`default_nettype wire

// ---- glcd_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module glcd_props (
    input wire logic mclk_i,
    input wire logic nrst_i,
    input wire logic chip_select_left,
    input wire logic chip_select_right,
    input wire logic di,
    input wire logic rw,
    input wire logic en,
    input wire logic res_n,
    input wire logic [7:0] host_db,
    input wire logic host_db_oe,
    input wire logic [7:0] dev_db,
    input wire logic dev_db_oe,
    input wire logic [7:0] db
);
    logic poll_ok_r;

    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!nrst_i);

    // Last finished status poll said ready; any other cycle or a pin reset forces a fresh poll
    always_ff @(posedge mclk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            poll_ok_r <= 1'b0;
        end else if (!res_n) begin
            poll_ok_r <= 1'b0;
        end else if ($fell(en) && chip_select_left) begin
            poll_ok_r <= rw && !di && !db[7] && !db[4]; // Non-status cycles use it up
        end
    end

    sel_pair_a: assert property (chip_select_left == chip_select_right)
        else $error("chip selects not driven together");
    no_clash_a: assert property (!(dev_db_oe && host_db_oe))
        else $error("both ends drive the data bus");
    dev_drive_a: assert property (dev_db_oe |-> $past(chip_select_left && chip_select_right && rw && en, 3))
        else $error("device drives bus without a selected read");
    rd_drive_a: assert property (($fell(en) && chip_select_left && rw) |-> dev_db_oe)
        else $error("read data not on bus when strobe falls");
    rd_release_a: assert property (($fell(en) && rw) |-> ##[2:8] !dev_db_oe)
        else $error("device keeps the bus after the read");
    status_zero_a: assert property ((dev_db_oe && !di) |-> (dev_db[6] == 1'b0 && dev_db[3:0] == 4'h0))
        else $error("unused status bits not zero");
    wr_hold_a: assert property ((en && $past(en) && !rw) |-> ($stable(host_db) && $stable(di)))
        else $error("write data moved while strobe high");
    poll_first_a: assert property (($rose(en) && !(rw && !di)) |-> poll_ok_r)
        else $error("command issued without a ready status");
    en_width_a: assert property ($rose(en) |-> en[*8])
        else $error("strobe high phase too short");
endmodule
`default_nettype wire

// ---- glcd_instruction_decoder_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module glcd_instruction_decoder_tb;
    import glcd_pkg::*;

    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic panel_rst = 1'b0;
    logic cmd_valid = 1'b0;
    logic cmd_di = 1'b0;
    logic cmd_rw = 1'b0;
    logic [7:0] cmd_data = 8'h00;
    logic [5:0] scan_row = 6'h00;
    logic [5:0] scan_col = 6'h00;
    logic cmd_ready;
    logic rsp_valid;
    logic [7:0] rsp_data;
    logic scan_pix;
    logic disp_on;
    logic busy;
    logic [5:0] start_line;
    logic [7:0] q;
    int err_total = 0;
    int cmp_count = 0;

    glcd_bus_if bus_if();
    // Shortest legal busy span keeps the run brief; init outlasts the first status read
    glcd_dev #(.BUSY_CYCLES(125), .INIT_CYCLES(50)) u_glcd_dev (.mclk_i(mclk), .nrst_i(nrst), .bus(bus_if),
        .scan_row_i(scan_row), .scan_col_i(scan_col), .scan_pix_o(scan_pix), .disp_on_o(disp_on),
        .start_line_o(start_line), .busy_o(busy));
    glcd_host u_glcd_host (.mclk_i(mclk), .nrst_i(nrst), .bus(bus_if), .panel_reset_i(panel_rst),
        .cmd_valid_i(cmd_valid), .cmd_di_i(cmd_di), .cmd_rw_i(cmd_rw), .cmd_data_i(cmd_data),
        .cmd_ready_o(cmd_ready), .rsp_valid_o(rsp_valid), .rsp_data_o(rsp_data));
    glcd_props u_glcd_props (.mclk_i(mclk), .nrst_i(nrst), .chip_select_left(bus_if.chip_select_left),
        .chip_select_right(bus_if.chip_select_right), .di(bus_if.di), .rw(bus_if.rw), .en(bus_if.en),
        .res_n(bus_if.res_n), .host_db(bus_if.host_db), .host_db_oe(bus_if.host_db_oe),
        .dev_db(bus_if.dev_db), .dev_db_oe(bus_if.dev_db_oe), .db(bus_if.db));

    // Free running 50 MHz clock
    always #10 mclk = ~mclk;

    task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h got %h", what, exp, got);
        end
    endtask

    // One user command; bounded waits so a stuck handshake cannot hang
    task automatic cmd(input logic di, input logic rw, input logic [7:0] d, output logic [7:0] r);
        int n;
        @(posedge mclk) #1;
        cmd_valid = 1'b1;
        cmd_di = di;
        cmd_rw = rw;
        cmd_data = d;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 5000) begin
            @(posedge mclk) #1;
            n++;
        end
        cmd_valid = 1'b0;
        while (rw && rsp_valid !== 1'b1 && n < 5000) begin
            @(posedge mclk) #1;
            n++;
        end
        check("handshake", 8'h01, {7'h00, n < 5000});
        r = rsp_data;
    endtask

    // Write, then an immediate status read that must still see busy
    task automatic put(input logic di, input logic [7:0] d);
        cmd(di, 1'b0, d, q);
        cmd(1'b0, 1'b1, 8'h00, q);
        check("busy after accept", 8'h80, q & 8'h80);
        check("busy_o after accept", 8'h01, {7'h00, busy});
    endtask

    task automatic t_reset();
        check("display on after reset", 8'h00, {7'h00, disp_on});
        check("start line after reset", 8'h00, {2'h0, start_line});
        cmd(1'b0, 1'b1, 8'h00, q);
        check("status after reset", 8'h30, q);
    endtask

    task automatic t_onoff();
        put(1'b0, 8'h3f);
        check("display on", 8'h01, {7'h00, disp_on});
        repeat (375) @(posedge mclk);
        #1;
        cmd(1'b0, 1'b1, 8'h00, q);
        check("status after busy span", 8'h00, q);
        check("busy_o after busy span", 8'h00, {7'h00, busy});
        put(1'b0, 8'h3f);
    endtask

    task automatic t_start();
        put(1'b0, 8'hff);
        check("start line 63", 8'h3f, {2'h0, start_line});
        put(1'b0, 8'hc0);
        check("start line 0", 8'h00, {2'h0, start_line});
    endtask

    // Codes outside the set touch nothing, not even busy
    task automatic t_undef();
        cmd(1'b0, 1'b0, 8'h87, q);
        cmd(1'b0, 1'b1, 8'h00, q);
        check("status after unknown code", 8'h00, q);
        check("start line kept", 8'h00, {2'h0, start_line});
    endtask

    // Last column then wrap, read back through the dummy cycle
    task automatic t_data();
        put(1'b0, 8'hbd);
        put(1'b0, 8'h7f);
        put(1'b1, 8'haa);
        put(1'b1, 8'h55);
        put(1'b0, 8'h7f);
        cmd(1'b1, 1'b1, 8'h00, q);
        check("read column 63", 8'haa, q);
        cmd(1'b1, 1'b1, 8'h00, q);
        check("read column 0", 8'h55, q);
    endtask

    task automatic pix(input logic [5:0] row, input logic exp);
        @(posedge mclk) #1;
        scan_row = row;
        scan_col = 6'h3f;
        repeat (2) @(posedge mclk);
        #1;
        check("pixel", {7'h00, exp}, {7'h00, scan_pix});
    endtask

    // Page 5 bit 1 is lit, bit 0 dark; scroll and blanking both tried
    task automatic t_scan();
        pix(6'd41, 1'b1);
        pix(6'd40, 1'b0);
        put(1'b0, 8'hc5);
        pix(6'd36, 1'b1);
        put(1'b0, 8'h3e);
        pix(6'd36, 1'b0);
        put(1'b0, 8'h3f);
        pix(6'd36, 1'b1);
    endtask

    task automatic t_pinrst();
        @(posedge mclk) #1;
        panel_rst = 1'b1;
        repeat (60) @(posedge mclk);
        #1;
        check("display on in pin reset", 8'h00, {7'h00, disp_on});
        check("start line in pin reset", 8'h00, {2'h0, start_line});
        panel_rst = 1'b0;
        cmd(1'b0, 1'b1, 8'h00, q);
        check("status after pin reset", 8'h30, q);
        put(1'b0, 8'h3f);
        check("display on after reinit", 8'h01, {7'h00, disp_on});
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge mclk);
        #1;
        nrst = 1'b1;
        t_reset();
        t_onoff();
        t_start();
        t_undef();
        t_data();
        t_scan();
        t_pinrst();
        stop_test();
    end

    // Whole run needs well under 20000 cycles
    initial begin
        #1000000;
        err_total++;
        $display("[FAIL] watchdog expected done got timeout");
        stop_test();
    end
endmodule
`default_nettype wire
